// ==== shared/cra_consts.svh ====
`ifndef CRA_CONSTS_SVH
`define CRA_CONSTS_SVH
// Memory organisation
`define CRA_WORDS 40
`define CRA_BLOCKS 5
`define CRA_BLK_WORDS 8
`define CRA_CODE_W 3
`define CRA_LOW_W 3
`define CRA_ADDR_W 6
// Block codes
`define CRA_BLK_IMPEDANCE_MATCH 3'h0
`define CRA_BLK_ECHO 3'h1
`define CRA_BLK_TONE_SCALING 3'h2
`define CRA_BLK_TRANSMIT 3'h3
`define CRA_BLK_RECEIVE 3'h4
`define CRA_BLK_LAST 3'h4
// Low word bounds of a walk
`define CRA_LOW_FIRST 3'h7
`define CRA_LOW_LAST 3'h0
// Low word codes inside the tone and scaling block
`define CRA_TONE1_AMP 3'h7
`define CRA_TONE1_FREQ 3'h6
`define CRA_TONE0_AMP 3'h5
`define CRA_TONE0_FREQ 3'h4
// Split points inside the transmit and receive blocks
`define CRA_GAIN_LOW_MIN 3'h4
`endif

// ==== shared/cra_pkg.sv ====
package cra_pkg;
  // Walk state
  typedef enum logic {CRA_IDLE, CRA_WALK} cra_state_t;
  // Word roles, as decoded from the full address
  typedef enum logic [3:0] {
    CRA_ROLE_IMPEDANCE_MATCH_FILTER,
    CRA_ROLE_ECHO_FILTER,
    CRA_ROLE_TONE1_AMP,
    CRA_ROLE_TONE1_FREQ,
    CRA_ROLE_TONE0_AMP,
    CRA_ROLE_TONE0_FREQ,
    CRA_ROLE_IMPEDANCE_SCALING,
    CRA_ROLE_TRANSMIT_GAIN,
    CRA_ROLE_TRANSMIT_FREQ_RESPONSE,
    CRA_ROLE_RECEIVE_GAIN,
    CRA_ROLE_RECEIVE_FREQ_RESPONSE,
    CRA_ROLE_NONE
  } cra_role_t;
  // All walk state of the addressing block
  typedef struct packed {
    cra_state_t state;
    logic [2:0] block;
    logic [2:0] low;
    logic busy;
    logic done;
  } cra_regs_t;
endpackage : cra_pkg

// ==== design/cra_block_addr.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cra_consts.svh"
module cra_block_addr
  import cra_pkg::*;
#(
  parameter int unsigned CODE_W = `CRA_CODE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Command from the serial control port decoder
  input wire logic cmd_valid,
  input wire logic [CODE_W-1:0] cmd_block,
  output logic cmd_ready,
  output logic cmd_reject,
  // Word transfer handshake
  input wire logic word_done,
  // Coefficient memory addressing
  output logic [`CRA_ADDR_W-1:0] word_addr,
  output logic word_valid,
  output cra_role_t word_role,
  output logic block_busy,
  output logic block_end
);

  // Reset release through two flip-flops
  logic [1:0] rst_sync_q;
  logic rst_int_b;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_int_b = rst_sync_q[1];

  // Role of a word from its full address
  function automatic cra_role_t role_of(input logic [2:0] blk, input logic [2:0] lo);
    cra_role_t r;
    r = CRA_ROLE_NONE;
    unique case (blk)
      `CRA_BLK_IMPEDANCE_MATCH: r = CRA_ROLE_IMPEDANCE_MATCH_FILTER;
      `CRA_BLK_ECHO: r = CRA_ROLE_ECHO_FILTER;
      `CRA_BLK_TONE_SCALING: begin
        unique case (lo)
          `CRA_TONE1_AMP: r = CRA_ROLE_TONE1_AMP;
          `CRA_TONE1_FREQ: r = CRA_ROLE_TONE1_FREQ;
          `CRA_TONE0_AMP: r = CRA_ROLE_TONE0_AMP;
          `CRA_TONE0_FREQ: r = CRA_ROLE_TONE0_FREQ;
          default: r = CRA_ROLE_IMPEDANCE_SCALING;
        endcase
      end
      `CRA_BLK_TRANSMIT: r = (lo >= `CRA_GAIN_LOW_MIN) ? CRA_ROLE_TRANSMIT_GAIN
                                                      : CRA_ROLE_TRANSMIT_FREQ_RESPONSE;
      `CRA_BLK_RECEIVE: r = (lo >= `CRA_GAIN_LOW_MIN) ? CRA_ROLE_RECEIVE_GAIN
                                                     : CRA_ROLE_RECEIVE_FREQ_RESPONSE;
      default: r = CRA_ROLE_NONE;
    endcase
    return r;
  endfunction : role_of

  cra_regs_t q, d;
  logic code_ok;

  // Codes above the last block do not exist; they are refused
  assign code_ok = (cmd_block <= `CRA_BLK_LAST);

  // Next state: idle takes a code, walk counts down one word per transfer
  always_comb begin
    d = q;
    d.done = 1'h0;
    unique case (q.state)
      CRA_IDLE: begin
        if (cmd_valid && code_ok) begin
          d.state = CRA_WALK;
          d.block = cmd_block[2:0];
          d.low = `CRA_LOW_FIRST;
          d.busy = 1'h1;
        end
      end
      CRA_WALK: begin
        if (word_done) begin
          if (q.low == `CRA_LOW_LAST) begin
            // Last word moved: free for a new command
            d.state = CRA_IDLE;
            d.busy = 1'h0;
            d.done = 1'h1;
          end else begin
            d.low = q.low - 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_int_b) begin
    if (!rst_int_b) begin
      q <= '{state: CRA_IDLE, block: 3'h0, low: 3'h0, busy: 1'h0, done: 1'h0};
    end else begin
      q <= d;
    end
  end

  // Outputs; commands are only taken while idle, so a walk is never cut short
  assign cmd_ready = (q.state == CRA_IDLE);
  assign cmd_reject = cmd_valid && (q.state == CRA_IDLE) && !code_ok;
  assign word_addr = {q.block, q.low};
  assign word_valid = q.busy;
  assign word_role = role_of(q.block, q.low);
  assign block_busy = q.busy;
  assign block_end = q.done;

  // Checks; each walk is built from these steps
  sequence s_take;
    cmd_valid && cmd_ready && code_ok;
  endsequence
  sequence s_first_word;
    word_valid && word_addr[2:0] == `CRA_LOW_FIRST;
  endsequence
  sequence s_stall;
    word_valid && !word_done;
  endsequence
  sequence s_prompt_walk;
    s_take ##1 word_done [*8];
  endsequence

  // A taken code starts at the top word of its own block
  chk_take_starts_top: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    s_take |=> s_first_word ##0 (word_addr[5:3] == $past(cmd_block[2:0])))
    else $error("walk did not start at top word of the given block");
  // Each moved word except the last steps the low bits down by one
  chk_step_down: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_done && word_addr[2:0] != `CRA_LOW_LAST
    |=> word_valid && word_addr[2:0] == $past(word_addr[2:0]) - 3'h1)
    else $error("walk did not step down by one");
  // A stalled word keeps its full address until the host moves it
  chk_stall_holds: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    s_stall |=> word_valid && $stable(word_addr))
    else $error("address moved while the host stalled");
  // A host that never stalls frees the block right after its eighth word
  chk_walk_eight: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    s_prompt_walk |=> block_end && !word_valid && cmd_ready)
    else $error("prompt walk did not end after eight words");

  // The block code stays put for the whole walk
  chk_block_held: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && $past(word_valid) |-> $stable(word_addr[5:3]))
    else $error("block changed during a walk");
  // A command during a walk is neither taken nor rejected; the walk runs on
  chk_busy_ignored: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && cmd_valid
    |-> (!cmd_ready && !cmd_reject) ##1 (word_valid || block_end))
    else $error("command during a walk was not ignored");

  // End of a block: one pulse, only after the last word, then idle
  chk_end_after_last: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_done && word_addr[2:0] == `CRA_LOW_LAST
    |=> block_end && !word_valid && cmd_ready)
    else $error("walk did not end after last word");
  chk_end_one_shot: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    block_end |=> !block_end)
    else $error("block end lasted more than one cycle");
  chk_end_cause: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    block_end |-> $past(word_valid) && $past(word_done)
    && $past(word_addr[2:0]) == `CRA_LOW_LAST)
    else $error("block end without a last word");
  // Idle means no word is presented to the memory
  chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    cmd_ready |-> !word_valid && !block_busy)
    else $error("word presented while idle");

  // Address space and its composition
  chk_block_range: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid |-> word_addr < 6'(`CRA_WORDS))
    else $error("address beyond forty words");
  chk_addr_concat: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    s_take ##1 word_done [*3] |=> word_addr == {$past(word_addr[5:3], 1), 3'h4})
    else $error("address not formed from block and count");

  // Roles of the gain and response blocks split at the middle word
  chk_receive_split: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr[5:3] == `CRA_BLK_RECEIVE
    |-> word_role == (word_addr[2] ? CRA_ROLE_RECEIVE_GAIN : CRA_ROLE_RECEIVE_FREQ_RESPONSE))
    else $error("receive block role wrong");
  chk_transmit_split: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr[5:3] == `CRA_BLK_TRANSMIT
    |-> word_role == (word_addr[2] ? CRA_ROLE_TRANSMIT_GAIN
                                   : CRA_ROLE_TRANSMIT_FREQ_RESPONSE))
    else $error("transmit block role wrong");
  // Every word of the two filter blocks carries its block's role
  chk_match_role: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr[5:3] == `CRA_BLK_IMPEDANCE_MATCH
    |-> word_role == CRA_ROLE_IMPEDANCE_MATCH_FILTER)
    else $error("impedance match block role wrong");
  chk_echo_role: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr[5:3] == `CRA_BLK_ECHO |-> word_role == CRA_ROLE_ECHO_FILTER)
    else $error("echo block role wrong");

  // Tone words sit at the top of the tone block, scaling words below them
  chk_tone_roles: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr == {`CRA_BLK_TONE_SCALING, `CRA_TONE1_AMP}
    |-> word_role == CRA_ROLE_TONE1_AMP)
    else $error("tone amplitude role wrong");
  chk_tone1_freq: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr == {`CRA_BLK_TONE_SCALING, `CRA_TONE1_FREQ}
    |-> word_role == CRA_ROLE_TONE1_FREQ)
    else $error("tone one frequency role wrong");
  chk_tone0_amp: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr == {`CRA_BLK_TONE_SCALING, `CRA_TONE0_AMP}
    |-> word_role == CRA_ROLE_TONE0_AMP)
    else $error("tone zero amplitude role wrong");
  chk_tone0_freq: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr == {`CRA_BLK_TONE_SCALING, `CRA_TONE0_FREQ}
    |-> word_role == CRA_ROLE_TONE0_FREQ)
    else $error("tone zero frequency role wrong");
  chk_scaling_role: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    word_valid && word_addr[5:3] == `CRA_BLK_TONE_SCALING
    && word_addr[2:0] < `CRA_TONE0_FREQ |-> word_role == CRA_ROLE_IMPEDANCE_SCALING)
    else $error("scaling word role wrong");

  // Codes past the last block are refused and start nothing
  chk_bad_refused: assert property (@(posedge clk_sys) disable iff (!rst_int_b)
    cmd_valid && cmd_ready && !code_ok |-> cmd_reject ##1 !word_valid)
    else $error("illegal block code accepted");

endmodule : cra_block_addr
`default_nettype wire

// ==== bench/cra_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Host side of the word transfers; slow mode stalls on random cycles
module cra_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pace control
  input wire logic slow,
  // Transfer strobe
  output logic word_done
);
  // Prompt mode keeps done high so every word goes back to back
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) word_done <= 1'b0;
    else word_done <= slow ? 1'($urandom) : 1'b1;
  end
endmodule : cra_host_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb
  import cra_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_block = 3'h0;
  logic slow = 1'b0;
  logic cmd_ready, cmd_reject, word_done, word_valid, block_busy, block_end;
  logic [5:0] word_addr;
  cra_role_t word_role;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // Design and the host model facing it
  cra_block_addr cra_block_addr_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_block(cmd_block), .cmd_ready(cmd_ready),
    .cmd_reject(cmd_reject), .word_done(word_done), .word_addr(word_addr),
    .word_valid(word_valid), .word_role(word_role), .block_busy(block_busy),
    .block_end(block_end));
  cra_host_model cra_host_model_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .slow(slow), .word_done(word_done));
  always #5 clk_sys = ~clk_sys;
  // Hang guard, far above twenty-one walks with stalls
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(string what, logic [5:0] exp, logic [5:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_role(cra_role_t exp, cra_role_t got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR word_role expected %0d seen %0d", exp, got);
    end
  endtask : cmp_role
  // Role of a word; tone roles are consecutive in the enum, low 7 first
  function automatic cra_role_t exp_role(logic [2:0] b, logic [2:0] l);
    case (b)
      3'h0: return CRA_ROLE_IMPEDANCE_MATCH_FILTER;
      3'h1: return CRA_ROLE_ECHO_FILTER;
      3'h2: return l > 3'h3 ? cra_role_t'(4'h9 - l) : CRA_ROLE_IMPEDANCE_SCALING;
      3'h3: return l > 3'h3 ? CRA_ROLE_TRANSMIT_GAIN : CRA_ROLE_TRANSMIT_FREQ_RESPONSE;
      default: return l > 3'h3 ? CRA_ROLE_RECEIVE_GAIN : CRA_ROLE_RECEIVE_FREQ_RESPONSE;
    endcase
  endfunction : exp_role
  // One command, then follow all eight words as the host moves them
  task automatic run_block(logic [2:0] code);
    int n;
    cmd_valid <= 1'b1;
    cmd_block <= code;
    #1;
    cmp("cmd_reject", 1'b0, cmd_reject);
    @(posedge clk_sys);
    cmd_block <= ~code; // A second command, held while busy, must not steer the walk
    #1;
    cmp("cmd_ready", 1'b0, cmd_ready);
    for (int l = 7; l >= 0; l--) begin
      n = 0;
      while (word_done !== 1'b1 && n < 50) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      if (n == 50) errors++; // Host stall ran past its limit
      cmp("word_addr", {code, 3'(l)}, word_addr);
      cmp_role(exp_role(code, 3'(l)), word_role);
      cmp("block_busy", 1'b1, block_busy);
      cmp("cmd_reject", 1'b0, cmd_reject);
      @(posedge clk_sys);
      if (l == 1) cmd_valid <= 1'b0; // Withdrawn before the walk ends
      #1;
    end
    cmp("block_end", 1'b1, block_end);
    cmp("word_valid", 1'b0, word_valid);
  endtask : run_block
  // Codes beyond the last block are dropped at once
  task automatic reject(logic [2:0] code);
    cmd_valid <= 1'b1;
    cmd_block <= code;
    #1;
    cmp("cmd_reject", 1'b1, cmd_reject);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    cmp("word_valid", 1'b0, word_valid);
    @(posedge clk_sys);
  endtask : reject
  // Idle state, as held by reset
  task automatic check_idle();
    cmp("cmd_ready", 1'b1, cmd_ready);
    cmp("word_valid", 1'b0, word_valid);
    cmp("block_busy", 1'b0, block_busy);
    cmp("word_addr", 6'h00, word_addr);
    cmp("block_end", 1'b0, block_end);
  endtask : check_idle
  // Reset in mid-walk drops the walk at once; the block restarts idle
  task automatic cut_walk(logic [2:0] code);
    cmd_valid <= 1'b1;
    cmd_block <= code;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b0;
    #1;
    check_idle();
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : cut_walk
  initial begin
    void'($urandom(25032));
    repeat (4) @(posedge clk_sys);
    #1;
    check_idle();
    @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int c = 5; c < 8; c++) reject(3'(c));
    for (int c = 0; c < 5; c++) begin
      run_block(3'(c));
      @(posedge clk_sys);
    end
    cut_walk(3'h4);
    run_block(3'h2);
    @(posedge clk_sys);
    repeat (15) begin
      slow <= 1'($urandom);
      run_block(3'($urandom_range(0, 4)));
      @(posedge clk_sys);
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
